// ===== dv/mcct_tgt_model.sv
`timescale 1ns/100ps
module mcct_tgt_model
	import mcct_pkg::*;
(
	// clock and reset
	input  logic                           clk,
	input  logic                           rst,
	// gating and override from the controller
	input  logic                           clk_en,
	input  logic                           uaddr_sel,
	input  logic [mcct_pkg::UADDR_W-1:0]   uaddr_out,
	// mark writes into the control store
	input  logic                           mark_we,
	input  logic [mcct_pkg::UADDR_W-1:0]   mark_addr,
	input  logic                           mark_bit,
	// target state seen by the controller
	output logic [mcct_pkg::UADDR_W-1:0]   uaddr,
	output logic [mcct_pkg::LOGIC_W-1:0]   logic_pts,
	output logic                           uinstr_end,
	output logic [mcct_pkg::NARROW_W-1:0]  probe,
	output logic                           mark_hit
);
	import mcct_pkg::*;
	logic [UADDR_W-1:0]      seq_q;
	logic [1:0]              phase_q;
	logic [(1<<UADDR_W)-1:0] marks_q = '0;
	// sequencer moves only on gated pulses, three cycles per instruction
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seq_q <= '0;
			phase_q <= 2'h0;
		end else if (clk_en) begin
			seq_q <= (uaddr_sel ? uaddr_out : seq_q) + 12'h001;
			phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
		end
	end
	// one stored bit per address marks where to break
	always @(posedge clk) begin
		if (mark_we) marks_q[mark_addr] <= mark_bit;
	end
	// outputs follow the sequencer address, except the instruction end, which follows the phase
	assign uaddr      = seq_q;
	assign logic_pts  = {8'h5A, seq_q};
	assign uinstr_end = (phase_q == 2'h2);
	assign probe      = {32'h0F0F_0F0F, 4'h0, seq_q};
	assign mark_hit   = marks_q[seq_q];
endmodule

// ===== dv/mcct_top_tb_top.sv
`timescale 1ns/100ps
module mcct_top_tb_top;
	import mcct_pkg::*;
	// ---------------------------------------------------------------
	// stimulus and observed signals
	// ---------------------------------------------------------------
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	logic                 cmd_valid = 1'b0;
	mcct_op_t             cmd_op = OP_NOP;
	logic [2:0]           cmd_idx = 3'h0;
	logic [UADDR_W-1:0]   cmd_a = '0;
	logic [UADDR_W-1:0]   cmd_b = '0;
	logic [WIDE_W-1:0]    cmd_data = '0;
	logic [WIDE_W-1:0]    cmd_mask = '0;
	logic                 panel = 1'b0;
	logic [NUM_EXT-1:0]   ext_tb = '0;
	logic                 trc_ready = 1'b1;
	logic                 cmd_ready, clk_en, uaddr_sel, mark_we, mark_bit, uinstr_end, mark_hit, trc_rec, out_valid;
	logic [UADDR_W-1:0]   uaddr_out, mon_uaddr, mark_addr, tgt_uaddr;
	logic [LOGIC_W-1:0]   mon_logic, tgt_logic;
	logic [NUM_HALT-1:0]  halt_cause;
	logic [TRC_BRK_N-1:0] trc_brk;
	logic [8:0]           trc_count;
	logic [NARROW_W-1:0]  probe;
	logic [79:0]          out_data;
	logic [NUM_EXT-1:0]   ext_halt;
	int                   bad_count = 0;
	int                   samples_checked = 0;
	int                   cycles = 0;
	assign ext_halt = ext_tb | {3'h0, mark_hit};
	// clock source
	always #12.5 clk = ~clk;
	mcct_top i_dut (.REF_CLK(clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op),
		.CMD_IDX(cmd_idx), .CMD_ADDR_A(cmd_a), .CMD_ADDR_B(cmd_b), .CMD_DATA(cmd_data), .CMD_MASK(cmd_mask),
		.TGT_UADDR(tgt_uaddr), .TGT_LOGIC(tgt_logic), .TGT_UINSTR_END(uinstr_end), .PANEL_HALT(panel),
		.EXT_HALT(ext_halt), .TRC_PROBE(probe), .TGT_CLK_EN(clk_en), .UADDR_SEL(uaddr_sel),
		.UADDR_OUT(uaddr_out), .MON_UADDR(mon_uaddr), .MON_LOGIC(mon_logic), .HALT_CAUSE(halt_cause),
		.MARK_WE(mark_we), .MARK_ADDR(mark_addr), .MARK_BIT(mark_bit), .TRC_BRK(trc_brk), .TRC_REC(trc_rec),
		.TRC_COUNT(trc_count), .TRC_OUT_VALID(out_valid), .TRC_OUT_READY(trc_ready), .TRC_OUT_DATA(out_data));
	mcct_tgt_model i_tgt (.clk(clk), .rst(rst), .clk_en(clk_en), .uaddr_sel(uaddr_sel), .uaddr_out(uaddr_out),
		.mark_we(mark_we), .mark_addr(mark_addr), .mark_bit(mark_bit), .uaddr(tgt_uaddr), .logic_pts(tgt_logic),
		.uinstr_end(uinstr_end), .probe(probe), .mark_hit(mark_hit));
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// compare any value
	task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one command, held until the controller takes it
	task automatic cmd(input mcct_op_t op, input logic [11:0] a = 12'h000, input logic [11:0] b = 12'h000,
		input logic [95:0] d = 96'h0, input logic [95:0] m = 96'h0, input logic [2:0] ix = 3'h0);
		int n;
		@(negedge clk);
		cmd_op = op;
		cmd_a = a;
		cmd_b = b;
		cmd_data = d;
		cmd_mask = m;
		cmd_idx = ix;
		cmd_valid = 1'b1;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk("cmd_ready", 1, cmd_ready);
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask
	// count cycles with the target clock passed
	task automatic count_en(input int n, output int c);
		c = 0;
		repeat (n) begin
			if (clk_en === 1'b1) c++;
			@(negedge clk);
		end
	endtask
	task automatic wait_halt(input int lim);
		int n;
		n = 0;
		while (clk_en !== 1'b0 && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk("halted", 0, clk_en);
	endtask
	// jump the target to an address through the override
	task automatic goto(input logic [11:0] a);
		int c;
		cmd(OP_OVR_ON, a);
		chk("override select", 1, uaddr_sel);
		chk("override addr", a, uaddr_out);
		cmd(OP_STEP_CYC);
		count_en(4, c);
		chk("one cycle step", 1, c);
		cmd(OP_OVR_OFF);
		chk("override off", 0, uaddr_sel);
		chk("target at new addr", a + 12'h001, tgt_uaddr);
	endtask
	task automatic mark_walk(input mcct_op_t op, input logic [11:0] a, input logic [11:0] b);
		cmd(op, a, b);
		for (int k = 0; k <= int'(b - a); k++) begin
			chk("mark strobe", 1, mark_we);
			chk("mark addr", a + 12'(k), mark_addr);
			chk("mark value", op == OP_MARK_SET, mark_bit);
			chk("busy in walk", 0, cmd_ready);
			@(negedge clk);
		end
		chk("walk ends", 0, mark_we);
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_step();
		int c;
		goto(12'h100);
		chk("monitor addr", 12'h101, mon_uaddr);
		chk("monitor logic", {8'h5A, 12'h101}, mon_logic);
		cmd(OP_STEP_INSTR);
		count_en(8, c);
		cmd(OP_STEP_INSTR);
		count_en(8, c);
		chk("one instruction", 3, c);
		chk("at boundary", 0, uinstr_end);
		$display("test step done");
	endtask
	task automatic t_halt();
		int c;
		for (int i = 0; i < NUM_HALT; i++) begin
			cmd(OP_HALT_EN, 12'h000, 12'h000, 96'(7'h01 | (7'h01 << i)));
			if (i == HS_ACMP) cmd(OP_ADDR_CMP, tgt_uaddr + 12'h020);
			cmd(OP_RUN);
			panel = (i != HS_PANEL);
			count_en(4, c);
			panel = (i == HS_PANEL);
			chk("disabled source ignored", 4, c);
			if (i == HS_CONSOLE) cmd(OP_HALT);
			if (i >= HS_EXT) ext_tb[i-HS_EXT] = 1'b1;
			wait_halt(60);
			chk("halt cause", 7'h01 << i, halt_cause);
			panel = 1'b0;
			ext_tb = 4'h0;
			count_en(6, c);
			chk("stays halted", 0, c);
			chk("cause held", 7'h01 << i, halt_cause);
		end
		$display("test halt done");
	endtask
	task automatic t_marks();
		mark_walk(OP_MARK_SET, 12'h008, 12'h00C);
		mark_walk(OP_MARK_CLR, 12'h008, 12'h00A);
		mark_walk(OP_MARK_CLR, 12'h00B, 12'h00B);
		cmd(OP_HALT_EN, 12'h000, 12'h000, 96'h9);
		goto(12'h005);
		cmd(OP_RUN);
		wait_halt(30);
		chk("mark halt cause", 7'h08, halt_cause);
		chk("first marked addr", 12'h00D, tgt_uaddr);
		$display("test marks done");
	endtask
	task automatic t_trig();
		int c;
		int seen;
		logic [11:0] pos[2];
		cmd(OP_HALT_EN, 12'h000, 12'h000, 96'h61);
		for (int r = 0; r < 2; r++) begin
			// upper group undelayed first, then trigger 0 with a delay
			cmd(OP_TRIG_CMP, 12'h000, 12'h000, 96'h200, 96'hFFF, 3'(4 - 4 * r));
			cmd(OP_TRIG_DLY, 12'h000, 12'h000, 96'h80000 + 96'(3 * r), 96'h0, 3'(4 - 4 * r));
			goto(12'h1F0);
			cmd(OP_RUN);
			seen = 0;
			c = 0;
			while (clk_en === 1'b1 && c < 60) begin
				if (trc_brk[1 - r] === 1'b1) seen = 1;
				@(negedge clk);
				c++;
			end
			chk("trace break pulse", 1, seen);
			chk("trace halt cause", 7'h40 >> r, halt_cause);
			pos[r] = tgt_uaddr;
			cmd(OP_TRIG_DLY, 12'h000, 12'h000, 96'h0, 96'h0, 3'(4 - 4 * r));
		end
		chk("trigger delay", 12'h003, pos[1] - pos[0]);
		$display("test triggers done");
	endtask
	task automatic t_trace();
		logic [79:0] q[$];
		int c;
		int d;
		logic [8:0] n;
		cmd(OP_HALT_EN, 12'h000, 12'h000, 96'h1);
		goto(12'h300);
		cmd(OP_TRACE_CTL, 12'h000, 12'h000, 96'h3);
		chk("recording", 1, trc_rec);
		cmd(OP_RUN);
		count_en(40, c);
		cmd(OP_HALT);
		wait_halt(20);
		cmd(OP_TRACE_CTL);
		n = trc_count;
		chk("count in range", 1, n >= 9'd10 && n <= 9'd12);
		trc_ready = 1'b0;
		cmd(OP_DUMP);
		c = 0;
		while (q.size() < n && c < 400) begin
			if (out_valid === 1'b1 && trc_ready === 1'b1) q.push_back(out_data);
			@(negedge clk);
			c++;
			trc_ready = (c > 20) && c[0];
		end
		chk("dump length", 128'(n), q.size());
		for (int k = 1; k < q.size(); k++) begin
			d = int'(q[k][11:0] - q[k-1][11:0]);
			chk("store spacing", TRC_GAP, d);
			chk("time tag", 32'(d), q[k][47:16]);
			chk("top field", 0, q[k][79:48]);
		end
		trc_ready = 1'b1;
		$display("test trace done");
	endtask
	// start and stop triggers, both qualifying: only the stop sample lands
	task automatic t_window();
		int c;
		logic [8:0] n0;
		n0 = trc_count;
		cmd(OP_TRIG_CMP, 12'h000, 12'h000, 96'h410, 96'hFFF, 3'h1);
		cmd(OP_TRIG_DLY, 12'h000, 12'h000, 96'h50000, 96'h0, 3'h1);
		cmd(OP_TRIG_CMP, 12'h000, 12'h000, 96'h418, 96'hFFF, 3'h2);
		cmd(OP_TRIG_DLY, 12'h000, 12'h000, 96'h60000, 96'h0, 3'h2);
		goto(12'h400);
		cmd(OP_RUN);
		count_en(30, c);
		cmd(OP_HALT);
		wait_halt(20);
		chk("qualified stores", n0 + 9'd1, trc_count);
		chk("stopped by trigger", 0, trc_rec);
		$display("test window done");
	endtask
	// cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			bad_count++;
			$display("timeout after %0d cycles", cycles);
			conclude();
		end
	end
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk("ready in reset", 0, cmd_ready);
		chk("clock gated in reset", 0, clk_en);
		rst = 1'b0;
		@(negedge clk);
		chk("ready after reset", 1, cmd_ready);
		t_step();
		t_halt();
		t_marks();
		t_trig();
		t_trace();
		t_window();
		conclude();
	end
endmodule

// ===== pkg/mcct_pkg.sv
package mcct_pkg;
	// ---------------------------------------------------------------
	// target geometry
	// ---------------------------------------------------------------
	localparam int UADDR_W    = 12;
	localparam int LOGIC_W    = 20;
	localparam int NUM_EXT    = 4;
	localparam int NUM_HALT   = 7;
	// halt source bit positions
	localparam int HS_CONSOLE = 0;
	localparam int HS_PANEL   = 1;
	localparam int HS_ACMP    = 2;
	localparam int HS_EXT     = 3;
	// ---------------------------------------------------------------
	// trace geometry
	// ---------------------------------------------------------------
	localparam int NARROW_W   = 48;
	localparam int WIDE_W     = 96;
	localparam int TAG_W      = 32;
	localparam int BUF_DEPTH  = 256;
	localparam int FIFO_DEPTH = 8;
	localparam int NUM_TRIG   = 8;
	localparam int DLY_W      = 16;
	// trace breakpoint lines and the first external input they drive
	localparam int TRC_BRK_N  = 2;
	localparam int TRC_EXT_LO = 2;
	// trigger role bits
	localparam int ROLE_START = 0;
	localparam int ROLE_STOP  = 1;
	localparam int ROLE_QUAL  = 2;
	localparam int ROLE_BRK   = 3;
	localparam int ROLE_W     = 4;
	// role field position in the delay command data
	localparam int ROLE_LSB   = 16;
	// trace control bits
	localparam int TC_ARM     = 0;
	localparam int TC_TAG     = 1;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ     = 40_000_000;
	localparam int TRC_MAX_HZ = 10_000_000;
	// least cycles between two stored samples
	localparam int TRC_GAP    = (CLK_HZ + TRC_MAX_HZ - 1) / TRC_MAX_HZ;
	// ---------------------------------------------------------------
	// commands and states
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NOP, OP_STEP_CYC, OP_STEP_INSTR, OP_RUN, OP_HALT, OP_HALT_EN,
		OP_ADDR_CMP, OP_OVR_ON, OP_OVR_OFF, OP_MARK_SET, OP_MARK_CLR,
		OP_TRIG_CMP, OP_TRIG_DLY, OP_TRACE_CTL, OP_DUMP
	} mcct_op_t;
	typedef enum logic [1:0] {CK_HALTED, CK_ONE, CK_INSTR, CK_FREE} mcct_ck_t;
endpackage

// ===== rtl/mcct_fifo.sv
`timescale 1ns/100ps
module mcct_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  logic         clk,
	input  logic         rst,
	// filling side
	input  logic         in_valid,
	output logic         in_ready,
	input  logic [W-1:0] in_data,
	// draining side
	output logic         out_valid,
	input  logic         out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           rp;
		logic [AW-1:0]           wp;
		logic [CW-1:0]           cnt;
	} mcct_fifo_st_t;
	mcct_fifo_st_t s, n;
	logic          push;
	logic          pop;

	// flags straight from the fill count
	assign in_ready  = s.cnt != CW'(DEPTH);
	assign out_valid = s.cnt != '0;
	assign out_data  = s.mem[s.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointer and count update
	always_comb begin
		n = s;
		if (push) begin
			n.mem[s.wp] = in_data;
			n.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
		end
		if (pop)
			n.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
		n.cnt = s.cnt + CW'(push) - CW'(pop);
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s <= '0;
		else
			s <= n;
	end
endmodule

// ===== rtl/mcct_top.sv
// Function
// - step one cycle, one instruction, or run
// - sample microaddress and twenty logic points
// - substitute commanded microaddress for sequencer's
// - seven separately enabled halt sources stop running
// - set or clear marks, single or range
// - two external inputs carry two trace breakpoints, four triggers each
// - store qualified samples, 256 deep, rate-limited
// - wide sample option and dedicated tag option
// - eight comparators, each with 16-bit delay
// - triggers start, stop, qualify, raise breakpoints
// - tag counts target pulses between stored events
// - without tag storage, tag replaces upper data
// - halts and steps suppress target clock pulses
`timescale 1ns/100ps
module mcct_top
	import mcct_pkg::*;
#(
	parameter bit       WIDE_TRACE    = 1'b0,
	parameter bit       DEDICATED_TAG = 1'b0,
	parameter int       FIFO_DEPTH_P  = mcct_pkg::FIFO_DEPTH,
	localparam int      SW            = WIDE_TRACE ? mcct_pkg::WIDE_W : mcct_pkg::NARROW_W,
	localparam int      EW            = SW + mcct_pkg::TAG_W,
	localparam int      PTR_W         = $clog2(mcct_pkg::BUF_DEPTH)
) (
	// clock and reset
	input  logic                              REF_CLK,
	input  logic                              RST,
	// command port from the supervising processor
	input  logic                              CMD_VALID,
	output logic                              CMD_READY,
	input  mcct_pkg::mcct_op_t                CMD_OP,
	input  logic [2:0]                        CMD_IDX,
	input  logic [mcct_pkg::UADDR_W-1:0]      CMD_ADDR_A,
	input  logic [mcct_pkg::UADDR_W-1:0]      CMD_ADDR_B,
	input  logic [mcct_pkg::WIDE_W-1:0]       CMD_DATA,
	input  logic [mcct_pkg::WIDE_W-1:0]       CMD_MASK,
	// target side
	input  logic [mcct_pkg::UADDR_W-1:0]      TGT_UADDR,
	input  logic [mcct_pkg::LOGIC_W-1:0]      TGT_LOGIC,
	input  logic                              TGT_UINSTR_END,
	input  logic                              PANEL_HALT,
	input  logic [mcct_pkg::NUM_EXT-1:0]      EXT_HALT,
	input  logic [SW-1:0]                     TRC_PROBE,
	output logic                              TGT_CLK_EN,
	output logic                              UADDR_SEL,
	output logic [mcct_pkg::UADDR_W-1:0]      UADDR_OUT,
	// monitor and halt status
	output logic [mcct_pkg::UADDR_W-1:0]      MON_UADDR,
	output logic [mcct_pkg::LOGIC_W-1:0]      MON_LOGIC,
	output logic [mcct_pkg::NUM_HALT-1:0]     HALT_CAUSE,
	// breakpoint marking into the control store
	output logic                              MARK_WE,
	output logic [mcct_pkg::UADDR_W-1:0]      MARK_ADDR,
	output logic                              MARK_BIT,
	// trace status and read-out stream
	output logic [mcct_pkg::TRC_BRK_N-1:0]    TRC_BRK,
	output logic                              TRC_REC,
	output logic [PTR_W:0]                    TRC_COUNT,
	output logic                              TRC_OUT_VALID,
	input  logic                              TRC_OUT_READY,
	output logic [EW-1:0]                     TRC_OUT_DATA
);
	import mcct_pkg::*;
	localparam int GAP_W = $clog2(TRC_GAP + 1);
	localparam int GRP   = NUM_TRIG / TRC_BRK_N;

	typedef struct packed {
		mcct_ck_t                          ck;
		logic                              clk_en;
		logic [NUM_HALT-1:0]               halt_en;
		logic [NUM_HALT-1:0]               cause;
		logic [UADDR_W-1:0]                acmp;
		logic                              ovr;
		logic [UADDR_W-1:0]                ovr_addr;
		logic [UADDR_W-1:0]                mon_addr;
		logic [LOGIC_W-1:0]                mon_logic;
		logic                              walk;
		logic                              mark_val;
		logic [UADDR_W-1:0]                mark_addr;
		logic [UADDR_W-1:0]                mark_end;
		logic [NUM_TRIG-1:0][SW-1:0]       cval;
		logic [NUM_TRIG-1:0][SW-1:0]       cmask;
		logic [NUM_TRIG-1:0][DLY_W-1:0]    dly;
		logic [NUM_TRIG-1:0][DLY_W-1:0]    dcnt;
		logic [NUM_TRIG-1:0]               busy;
		logic [NUM_TRIG-1:0][ROLE_W-1:0]   role;
		logic                              rec;
		logic                              tag_en;
		logic [TAG_W-1:0]                  tag;
		logic [GAP_W-1:0]                  gap;
		logic [TRC_BRK_N-1:0]              brk;
		logic [PTR_W-1:0]                  wptr;
		logic [PTR_W-1:0]                  rptr;
		logic [PTR_W:0]                    cnt_st;
		logic [PTR_W:0]                    left;
		logic                              dump;
		logic [EW-1:0]                     out;
		logic                              out_v;
		logic                              rdy;
	} mcct_st_t;

	mcct_st_t            s, n;
	logic                acc;
	logic [NUM_EXT-1:0]  ext;
	logic [NUM_HALT-1:0] src;
	logic [NUM_HALT-1:0] hits;
	logic [NUM_TRIG-1:0] hit;
	logic [NUM_TRIG-1:0] fire;
	logic [ROLE_W-1:0]   act;
	logic                qual_used;
	logic                store;
	logic [EW-1:0]       word;
	logic                push;
	logic                fin_rdy;
	logic                pop;
	logic                fv;
	logic [EW-1:0]       fd;
	logic [EW-1:0]       tbuf [BUF_DEPTH];

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		n = s;
		acc = CMD_VALID && s.rdy;
		// latest target state for display
		n.mon_addr = TGT_UADDR;
		n.mon_logic = TGT_LOGIC;
		// trace breakpoints ride on two external inputs
		ext = EXT_HALT | {s.brk, {TRC_EXT_LO{1'b0}}};
		src = '0;
		src[HS_CONSOLE] = acc && CMD_OP == OP_HALT;
		src[HS_PANEL] = PANEL_HALT;
		src[HS_ACMP] = TGT_UADDR == s.acmp;
		src[HS_EXT +: NUM_EXT] = ext;
		hits = src & s.halt_en;
		// clock gate sequencing
		unique case (s.ck)
			CK_HALTED: ;
			CK_ONE: n.ck = CK_HALTED;
			CK_INSTR: if (TGT_UINSTR_END) n.ck = CK_HALTED;
			CK_FREE: if (|hits) begin
				n.ck = CK_HALTED;
				n.cause = hits;
			end
		endcase
		// trigger comparators and delays
		hit = '0;
		fire = '0;
		act = '0;
		qual_used = 1'b0;
		n.brk = '0;
		for (int i = 0; i < NUM_TRIG; i++) begin
			hit[i] = (((TRC_PROBE ^ s.cval[i]) & s.cmask[i]) == '0) && s.role[i] != '0;
			if (s.clk_en) begin
				if (s.busy[i]) begin
					n.dcnt[i] = s.dcnt[i] - 1'b1;
					if (s.dcnt[i] == DLY_W'(1)) begin
						fire[i] = 1'b1;
						n.busy[i] = 1'b0;
					end
				end else if (hit[i]) begin
					if (s.dly[i] == '0)
						fire[i] = 1'b1;
					else begin
						n.busy[i] = 1'b1;
						n.dcnt[i] = s.dly[i];
					end
				end
			end
			act = act | (fire[i] ? s.role[i] : '0);
			qual_used = qual_used | s.role[i][ROLE_QUAL];
			n.brk[i / GRP] = n.brk[i / GRP] | (fire[i] & s.role[i][ROLE_BRK]);
		end
		// record window, stop wins
		if (act[ROLE_START]) n.rec = 1'b1;
		if (act[ROLE_STOP]) n.rec = 1'b0;
		// qualified, rate-limited store
		store = s.rec && s.clk_en && (!qual_used || act[ROLE_QUAL]) && s.gap == '0 && !s.dump;
		word = {{TAG_W{1'b0}}, TRC_PROBE};
		if (s.tag_en) begin
			if (DEDICATED_TAG)
				word[EW-1 -: TAG_W] = s.tag + 1'b1;          // this pulse counts too
			else
				word[SW-1 -: TAG_W] = s.tag + 1'b1;
		end
		if (store) begin
			n.tag = '0;
			n.gap = GAP_W'(TRC_GAP - 1);
			n.wptr = s.wptr + 1'b1;
			if (s.cnt_st != (PTR_W + 1)'(BUF_DEPTH))
				n.cnt_st = s.cnt_st + 1'b1;
		end else begin
			if (s.tag_en && s.clk_en)
				n.tag = s.tag + 1'b1;
			if (s.gap != '0)
				n.gap = s.gap - 1'b1;
		end
		// read-out from oldest entry
		push = s.dump && s.left != '0;
		if (push && fin_rdy) begin
			n.rptr = s.rptr + 1'b1;
			n.left = s.left - 1'b1;
		end
		if (s.dump && s.left == '0)
			n.dump = 1'b0;
		// output register in front of the stream
		pop = !s.out_v || TRC_OUT_READY;
		if (pop) begin
			n.out_v = fv;
			if (fv) n.out = fd;
		end
		// range walk for marks
		if (s.walk) begin
			if (s.mark_addr == s.mark_end)
				n.walk = 1'b0;
			else
				n.mark_addr = s.mark_addr + 1'b1;
		end
		// command decode
		if (acc) begin
			unique case (CMD_OP)
				OP_STEP_CYC: if (s.ck == CK_HALTED) begin
					n.ck = CK_ONE;
					n.cause = '0;
				end
				OP_STEP_INSTR: if (s.ck == CK_HALTED) begin
					n.ck = CK_INSTR;
					n.cause = '0;
				end
				OP_RUN: if (s.ck == CK_HALTED) begin
					n.ck = CK_FREE;
					n.cause = '0;
				end
				OP_HALT_EN: n.halt_en = CMD_DATA[NUM_HALT-1:0];
				OP_ADDR_CMP: n.acmp = CMD_ADDR_A;
				OP_OVR_ON: begin
					n.ovr = 1'b1;
					n.ovr_addr = CMD_ADDR_A;
				end
				OP_OVR_OFF: n.ovr = 1'b0;
				OP_MARK_SET, OP_MARK_CLR: begin
					n.walk = 1'b1;
					n.mark_addr = CMD_ADDR_A;
					n.mark_end = (CMD_ADDR_B < CMD_ADDR_A) ? CMD_ADDR_A : CMD_ADDR_B;
					n.mark_val = CMD_OP == OP_MARK_SET;
				end
				OP_TRIG_CMP: begin
					n.cval[CMD_IDX] = CMD_DATA[SW-1:0];
					n.cmask[CMD_IDX] = CMD_MASK[SW-1:0];
				end
				OP_TRIG_DLY: begin
					n.dly[CMD_IDX] = CMD_DATA[DLY_W-1:0];
					n.role[CMD_IDX] = CMD_DATA[ROLE_LSB +: ROLE_W];
					n.busy[CMD_IDX] = 1'b0;
				end
				OP_TRACE_CTL: begin
					n.rec = CMD_DATA[TC_ARM];
					n.tag_en = CMD_DATA[TC_TAG];
					n.tag = '0;
				end
				OP_DUMP: begin
					n.dump = 1'b1;
					n.rptr = s.wptr - s.cnt_st[PTR_W-1:0];
					n.left = s.cnt_st;
				end
				OP_NOP, OP_HALT: ;
				default: ;
			endcase
		end
		n.clk_en = n.ck != CK_HALTED;
		n.rdy = !n.walk && !n.dump;
	end

	// ---------------------------------------------------------------
	// registers and trace memory
	// ---------------------------------------------------------------
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST)
			s <= '0;
		else
			s <= n;
	end

	// trace buffer write port
	always_ff @(posedge REF_CLK) begin
		if (store) tbuf[s.wptr] <= word;
	end

	// read-out buffering
	mcct_fifo #(.W(EW), .DEPTH(FIFO_DEPTH_P)) u_fifo (
		.clk       (REF_CLK),
		.rst       (RST),
		.in_valid  (push),
		.in_ready  (fin_rdy),
		.in_data   (tbuf[s.rptr]),
		.out_valid (fv),
		.out_ready (pop),
		.out_data  (fd)
	);

	// outputs from state flops
	assign CMD_READY     = s.rdy;
	assign TGT_CLK_EN    = s.clk_en;
	assign UADDR_SEL     = s.ovr;
	assign UADDR_OUT     = s.ovr_addr;
	assign MON_UADDR     = s.mon_addr;
	assign MON_LOGIC     = s.mon_logic;
	assign HALT_CAUSE    = s.cause;
	assign MARK_WE       = s.walk;
	assign MARK_ADDR     = s.mark_addr;
	assign MARK_BIT      = s.mark_val;
	assign TRC_BRK       = s.brk;
	assign TRC_REC       = s.rec;
	assign TRC_COUNT     = s.cnt_st;
	assign TRC_OUT_VALID = s.out_v;
	assign TRC_OUT_DATA  = s.out;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	sequence q_step_cyc;
		acc && CMD_OP == OP_STEP_CYC && s.ck == CK_HALTED;
	endsequence
	sequence q_one_pulse;
		s.clk_en ##1 !s.clk_en;
	endsequence
	sequence q_mark;
		acc && (CMD_OP == OP_MARK_SET || CMD_OP == OP_MARK_CLR);
	endsequence

	AST_STEP_CYC: assert property (q_step_cyc |=> q_one_pulse) else $error("cycle step not one pulse");
	AST_STEP_INS: assert property (s.ck == CK_INSTR && TGT_UINSTR_END |=> !TGT_CLK_EN)
		else $error("instruction step overran");
	AST_RUN: assert property (acc && CMD_OP == OP_RUN && s.ck == CK_HALTED
		|=> TGT_CLK_EN && s.ck == CK_FREE) else $error("run did not start");
	AST_HALT_SRC: assert property (s.ck == CK_FREE && |hits
		|=> !TGT_CLK_EN && HALT_CAUSE == $past(hits)) else $error("enabled halt ignored");
	AST_HOLD: assert property (s.ck == CK_HALTED
		&& !(acc && CMD_OP inside {OP_STEP_CYC, OP_STEP_INSTR, OP_RUN})
		|=> !TGT_CLK_EN && $stable(HALT_CAUSE)) else $error("halt not held");
	AST_OVR: assert property (acc && CMD_OP == OP_OVR_ON
		|=> UADDR_SEL && UADDR_OUT == $past(CMD_ADDR_A)) else $error("override address wrong");
	AST_MON: assert property (1'b1
		|=> MON_UADDR == $past(TGT_UADDR) && MON_LOGIC == $past(TGT_LOGIC)) else $error("monitor sample stale");
	AST_MARK: assert property (q_mark |=> MARK_WE && MARK_ADDR == $past(CMD_ADDR_A)
		&& MARK_BIT == $past(CMD_OP == OP_MARK_SET)) else $error("mark walk start wrong");
	AST_GAP: assert property (store |=> !store [*3]) else $error("trace rate exceeded");
	AST_TAG: assert property (store && s.tag_en |=> s.tag == '0) else $error("tag not restarted");
	AST_DLY: assert property (s.clk_en && !s.busy[0] && hit[0] && s.dly[0] != '0
		&& !(acc && CMD_OP == OP_TRIG_DLY)
		|=> s.busy[0] && s.dcnt[0] == $past(s.dly[0])) else $error("trigger delay not loaded");
	AST_BRK: assert property (|(fire[GRP-1:0] & {s.role[3][ROLE_BRK], s.role[2][ROLE_BRK],
		s.role[1][ROLE_BRK], s.role[0][ROLE_BRK]}) |=> TRC_BRK[0]) else $error("trace break lost");
endmodule
